//--- rtl/bjc_core.sv
/*
  bjc_core: executes bit-test jumps and subroutine calls loaded over apb.
  Assumes: operand data answers one cycle after the request pulse;
  stack writes are taken by the stack memory in the cycle they show.
*/
`include "bjc_params.svh"
`default_nettype none

module bjc_core
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operand fetch
  output var bjc_pkg::bjc_opnd_req_t opnd_req,
  input wire logic [23:0] opnd_rdata,
  input wire logic opnd_scale,
  input wire logic opnd_limit,
  // system stack and pipeline
  output var bjc_pkg::bjc_stack_wr_t stk_wr,
  output logic flush,
  output logic done
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a <= 12'h05C) && (a != 12'h01C);
  endfunction : addr_mapped

  function automatic logic bit_of(input logic [23:0] d, input logic [4:0] n);
    bit_of = d[n];
  endfunction : bit_of

  // ************************************************************
  // state
  // ************************************************************
  bjc_pkg::bjc_state_t state_r, state_nxt;
  logic [23:0] instr_r, instr_nxt;
  logic [15:0] ext_r, ext_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] sr_r, sr_nxt;
  logic [15:0] sp_r, sp_nxt;
  logic [15:0] ea_r, ea_nxt;
  logic [15:0] rn_r [8];
  logic [15:0] rn_nxt [8];
  logic [15:0] nn_r [8];
  logic [15:0] nn_nxt [8];
  logic illegal_r, illegal_nxt;
  logic taken_r, taken_nxt;
  logic flush_nxt, done_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  bjc_pkg::bjc_opnd_req_t opnd_r, opnd_nxt;
  bjc_pkg::bjc_stack_wr_t stk_r, stk_nxt;

  // ************************************************************
  // decode
  // ************************************************************
  bjc_pkg::bjc_op_t dec_op;
  bjc_pkg::bjc_form_t dec_form;
  logic dec_legal;
  logic [4:0] dec_bit;
  logic [15:0] dec_len;
  logic [15:0] ea_out, rn_upd;
  logic rn_we, uses_ext, ok_indirect, ok_alterable;
  logic wr_en, go, busy, tested, branch, push;
  logic [15:0] ret_pc, target;

  assign wr_en = psel && penable && pwrite;
  assign busy = (state_r != bjc_pkg::ST_IDLE);
  assign go = wr_en && !busy && (paddr == `BJC_OFF_CTRL) && pwdata[0];

  bjc_ea_unit u_ea
  (
    .mode(instr_r[13:11]),
    .rsel(instr_r[10:8]),
    .rn(rn_r[instr_r[10:8]]),
    .nn(nn_r[instr_r[10:8]]),
    .ext(ext_r),
    .ea(ea_out),
    .rn_upd(rn_upd),
    .rn_we(rn_we),
    .uses_ext(uses_ext),
    .ok_indirect(ok_indirect),
    .ok_alterable(ok_alterable)
  );

  always_comb
  begin
    dec_op = bjc_pkg::OP_NONE;
    dec_form = bjc_pkg::bjc_form_t'(instr_r[17:15]);
    dec_bit = instr_r[4:0];
    dec_len = 16'h0002;
    dec_legal = 1'b0;
    if (instr_r[23:20] == `BJC_BT_GROUP)
    begin
      unique case (instr_r[19:18])
        2'h0: dec_op = bjc_pkg::OP_JUMP_SET;
        2'h1: dec_op = bjc_pkg::OP_CALL_SET;
        2'h2: dec_op = bjc_pkg::OP_CALL_CLR;
        2'h3: dec_op = bjc_pkg::OP_NONE;
      endcase
      dec_legal = (dec_op != bjc_pkg::OP_NONE) && (dec_bit <= `BJC_BIT_MAX)
        && ((instr_r[17:15] != 3'h0) || ok_indirect)
        && (instr_r[17:15] <= 3'h4);
    end
    else if ((instr_r[23:16] == `BJC_CALL_EA_HI) && (instr_r[15:14] == `BJC_CALL_EA_MID)
      && (instr_r[7:0] == `BJC_CALL_EA_LO))
    begin
      dec_op = bjc_pkg::OP_CALL_EA;
      dec_legal = ok_alterable;
      dec_len = uses_ext ? 16'h0002 : 16'h0001;
    end
    else if (instr_r[23:12] == `BJC_CALL_SHORT)
    begin
      dec_op = bjc_pkg::OP_CALL_SHORT;
      dec_legal = 1'b1;
      dec_len = 16'h0001;
    end
  end

  // ************************************************************
  // execute
  // ************************************************************
  assign tested = bit_of(opnd_rdata, instr_r[4:0]);
  assign ret_pc = pc_r + dec_len;

  always_comb
  begin
    unique case (dec_op)
      bjc_pkg::OP_CALL_EA: target = ea_r;
      bjc_pkg::OP_CALL_SHORT: target = {4'h0, instr_r[11:0]};
      default: target = ext_r;
    endcase
    unique case (dec_op)
      bjc_pkg::OP_JUMP_SET: begin branch = tested; push = 1'b0; end
      bjc_pkg::OP_CALL_SET: begin branch = tested; push = tested; end
      bjc_pkg::OP_CALL_CLR: begin branch = !tested; push = !tested; end
      bjc_pkg::OP_CALL_EA, bjc_pkg::OP_CALL_SHORT:
      begin
        branch = 1'b1;
        push = 1'b1;
      end
      default: begin branch = 1'b0; push = 1'b0; end
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    ext_nxt = ext_r;
    pc_nxt = pc_r;
    sr_nxt = sr_r;
    sp_nxt = sp_r;
    ea_nxt = ea_r;
    rn_nxt = rn_r;
    nn_nxt = nn_r;
    illegal_nxt = illegal_r;
    taken_nxt = taken_r;
    flush_nxt = 1'b0;
    done_nxt = 1'b0;
    opnd_nxt = opnd_r;
    opnd_nxt.valid = 1'b0;
    stk_nxt = stk_r;
    stk_nxt.we = 1'b0;
    if (wr_en && !busy)
    begin
      unique case (paddr)
        `BJC_OFF_INSTR: instr_nxt = pwdata[23:0];
        `BJC_OFF_EXT: ext_nxt = pwdata[15:0];
        `BJC_OFF_PC: pc_nxt = pwdata[15:0];
        `BJC_OFF_SR: sr_nxt = pwdata[15:0];
        `BJC_OFF_SP: sp_nxt = pwdata[15:0];
        default:
        begin
          if (paddr[11:5] == 7'h01)
            rn_nxt[paddr[4:2]] = pwdata[15:0];
          else if (paddr[11:5] == 7'h02)
            nn_nxt[paddr[4:2]] = pwdata[15:0];
        end
      endcase
    end
    unique case (state_r)
      bjc_pkg::ST_IDLE:
      begin
        if (go)
        begin
          illegal_nxt = !dec_legal;
          ea_nxt = ea_out;
          if (!dec_legal)
            done_nxt = 1'b1;
          else
          begin
            if (rn_we && ((dec_op == bjc_pkg::OP_CALL_EA) || (dec_form == bjc_pkg::FM_EA)))
              rn_nxt[instr_r[10:8]] = rn_upd;
            if ((dec_op == bjc_pkg::OP_CALL_EA) || (dec_op == bjc_pkg::OP_CALL_SHORT))
              state_nxt = bjc_pkg::ST_EXEC;
            else
            begin
              state_nxt = bjc_pkg::ST_OPND;
              opnd_nxt.valid = 1'b1;
              opnd_nxt.space_y = instr_r[14];
              opnd_nxt.is_reg = (dec_form == bjc_pkg::FM_REG);
              opnd_nxt.reg_code = instr_r[13:8];
              unique case (dec_form)
                bjc_pkg::FM_ABS: opnd_nxt.addr = {10'h000, instr_r[13:8]};
                bjc_pkg::FM_IO_HI: opnd_nxt.addr = {`BJC_IO_HI_BASE, instr_r[13:8]};
                bjc_pkg::FM_IO_LO: opnd_nxt.addr = {`BJC_IO_LO_BASE, instr_r[13:8]};
                bjc_pkg::FM_EA: opnd_nxt.addr = ea_out;
                default: opnd_nxt.addr = 16'h0000;
              endcase
            end
          end
        end
      end
      bjc_pkg::ST_OPND: state_nxt = bjc_pkg::ST_EXEC;
      bjc_pkg::ST_EXEC:
      begin
        state_nxt = bjc_pkg::ST_IDLE;
        done_nxt = 1'b1;
        taken_nxt = branch;
        pc_nxt = branch ? target : ret_pc;
        flush_nxt = branch;
        if ((dec_op != bjc_pkg::OP_CALL_EA) && (dec_op != bjc_pkg::OP_CALL_SHORT))
        begin
          sr_nxt[`BJC_CCR_S] = sr_r[`BJC_CCR_S] | opnd_scale;
          sr_nxt[`BJC_CCR_L] = sr_r[`BJC_CCR_L] | opnd_limit;
        end
        if (push)
        begin
          sp_nxt = sp_r + 16'h0001;
          stk_nxt.we = 1'b1;
          stk_nxt.ptr = sp_r + 16'h0001;
          stk_nxt.high = ret_pc;
          stk_nxt.low = sr_r;
        end
      end
      default: state_nxt = bjc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= bjc_pkg::ST_IDLE;
      instr_r <= 24'h000000;
      ext_r <= 16'h0000;
      pc_r <= `BJC_RST_PC;
      sr_r <= `BJC_RST_SR;
      sp_r <= `BJC_RST_SP;
      ea_r <= 16'h0000;
      for (int i = 0; i < 8; i++)
      begin
        rn_r[i] <= 16'h0000;
        nn_r[i] <= 16'h0000;
      end
      illegal_r <= 1'b0;
      taken_r <= 1'b0;
      flush <= 1'b0;
      done <= 1'b0;
      opnd_r <= '0;
      stk_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      ext_r <= ext_nxt;
      pc_r <= pc_nxt;
      sr_r <= sr_nxt;
      sp_r <= sp_nxt;
      ea_r <= ea_nxt;
      rn_r <= rn_nxt;
      nn_r <= nn_nxt;
      illegal_r <= illegal_nxt;
      taken_r <= taken_nxt;
      flush <= flush_nxt;
      done <= done_nxt;
      opnd_r <= opnd_nxt;
      stk_r <= stk_nxt;
    end
  end

  assign opnd_req = opnd_r;
  assign stk_wr = stk_r;

  // ************************************************************
  // apb read path
  // ************************************************************
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign prdata = prdata_r;

  always_comb
  begin
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite)
    begin
      prdata_nxt = 32'h00000000;
      unique case (paddr)
        `BJC_OFF_STATUS: prdata_nxt = {29'h00000000, taken_r, illegal_r, busy};
        `BJC_OFF_INSTR: prdata_nxt = {8'h00, instr_r};
        `BJC_OFF_EXT: prdata_nxt = {16'h0000, ext_r};
        `BJC_OFF_PC: prdata_nxt = {16'h0000, pc_r};
        `BJC_OFF_SR: prdata_nxt = {16'h0000, sr_r};
        `BJC_OFF_SP: prdata_nxt = {16'h0000, sp_r};
        default:
        begin
          if (paddr[11:5] == 7'h01 && paddr[1:0] == 2'h0)
            prdata_nxt = {16'h0000, rn_r[paddr[4:2]]};
          else if (paddr[11:5] == 7'h02 && paddr[1:0] == 2'h0)
            prdata_nxt = {16'h0000, nn_r[paddr[4:2]]};
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h00000000;
    else
      prdata_r <= prdata_nxt;
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic exec;
  assign exec = (state_r == bjc_pkg::ST_EXEC);

  property p_jump_taken;
    exec && dec_op == bjc_pkg::OP_JUMP_SET && tested |=> pc_r == $past(ext_r) && flush;
  endproperty
  a_jump_taken: assert property (p_jump_taken) else $error("jump target wrong");

  property p_jump_skip;
    exec && dec_op == bjc_pkg::OP_JUMP_SET && !tested |=> pc_r == $past(pc_r) + 16'h0002;
  endproperty
  a_jump_skip: assert property (p_jump_skip) else $error("not-taken pc wrong");

  property p_bad_bit;
    go && instr_r[23:20] == `BJC_BT_GROUP && instr_r[4:0] > `BJC_BIT_MAX
      |=> illegal_r && state_r == bjc_pkg::ST_IDLE;
  endproperty
  a_bad_bit: assert property (p_bad_bit) else $error("bit above 23 accepted");

  property p_io_hi;
    go && dec_legal && instr_r[23:20] == `BJC_BT_GROUP && dec_form == bjc_pkg::FM_IO_HI
      |=> opnd_req.valid && opnd_req.addr[15:6] == 10'h3FF;
  endproperty
  a_io_hi: assert property (p_io_hi) else $error("io short high map wrong");

  property p_call_set_push;
    exec && dec_op == bjc_pkg::OP_CALL_SET && tested
      |=> stk_wr.we && stk_wr.ptr == sp_r && sp_r == $past(sp_r) + 16'h0001;
  endproperty
  a_call_set_push: assert property (p_call_set_push) else $error("push missing");

  property p_call_set_skip;
    exec && dec_op == bjc_pkg::OP_CALL_SET && !tested |=> !stk_wr.we && $stable(sp_r);
  endproperty
  a_call_set_skip: assert property (p_call_set_skip) else $error("stack touched");

  property p_call_clr;
    exec && dec_op == bjc_pkg::OP_CALL_CLR |=> stk_wr.we == !$past(tested);
  endproperty
  a_call_clr: assert property (p_call_clr) else $error("clear-call push wrong");

  property p_call_short;
    go && dec_legal && dec_op == bjc_pkg::OP_CALL_SHORT
      |=> ##1 pc_r == {4'h0, $past(instr_r[11:0], 2)} && stk_wr.we;
  endproperty
  a_call_short: assert property (p_call_short) else $error("short call wrong");

  property p_call_ccr;
    exec && (dec_op == bjc_pkg::OP_CALL_EA || dec_op == bjc_pkg::OP_CALL_SHORT)
      |=> $stable(sr_r);
  endproperty
  a_call_ccr: assert property (p_call_ccr) else $error("call changed ccr");

  property p_flush;
    flush |-> $past(exec) && taken_r;
  endproperty
  a_flush: assert property (p_flush) else $error("flush without branch");

  property p_entry;
    stk_wr.we |-> stk_wr.ptr == sp_r && stk_wr.low == $past(sr_r) && !$past(stk_wr.we);
  endproperty
  a_entry: assert property (p_entry) else $error("stack entry wrong");

  c_jump: cover property (exec && dec_op == bjc_pkg::OP_JUMP_SET && tested);
  c_call_set: cover property (exec && dec_op == bjc_pkg::OP_CALL_SET && tested);
  c_call_clr_skip: cover property (exec && dec_op == bjc_pkg::OP_CALL_CLR && tested);
  c_call_ea: cover property (exec && dec_op == bjc_pkg::OP_CALL_EA);

endmodule : bjc_core

`default_nettype wire

//--- rtl/bjc_ea_unit.sv
/*
  bjc_ea_unit: effective address and address register update.
  Assumes: register values are stable while the mode field is decoded.
*/
`default_nettype none

module bjc_ea_unit
(
  // mode field
  input wire logic [2:0] mode,
  input wire logic [2:0] rsel,
  // operands
  input wire logic [15:0] rn,
  input wire logic [15:0] nn,
  input wire logic [15:0] ext,
  // results
  output logic [15:0] ea,
  output logic [15:0] rn_upd,
  output logic rn_we,
  output logic uses_ext,
  output logic ok_indirect,
  output logic ok_alterable
);

  always_comb
  begin
    ea = rn;
    rn_upd = rn;
    rn_we = 1'b0;
    uses_ext = 1'b0;
    ok_indirect = (mode != 3'h6);
    ok_alterable = (mode != 3'h6) || (rsel == 3'h0);
    unique case (mode)
      3'h0: begin rn_upd = rn - nn; rn_we = 1'b1; end
      3'h1: begin rn_upd = rn + nn; rn_we = 1'b1; end
      3'h2: begin rn_upd = rn - 16'h0001; rn_we = 1'b1; end
      3'h3: begin rn_upd = rn + 16'h0001; rn_we = 1'b1; end
      3'h4: ea = rn;
      3'h5: ea = rn + nn;
      3'h6: begin ea = ext; uses_ext = 1'b1; end
      3'h7:
      begin
        ea = rn - 16'h0001;
        rn_upd = rn - 16'h0001;
        rn_we = 1'b1;
      end
    endcase
  end

endmodule : bjc_ea_unit

`default_nettype wire

//--- rtl/bjc_params.svh
/*
  bjc_params.svh: offsets, field positions, encodings and reset values
  for the bit-test jump and subroutine call unit.
  Assumes: included by bare name into the bjc_core module only.
*/
`ifndef BJC_PARAMS_SVH
`define BJC_PARAMS_SVH

// ************************************************************
// apb register byte offsets
// ************************************************************
`define BJC_OFF_CTRL   12'h000
`define BJC_OFF_STATUS 12'h004
`define BJC_OFF_INSTR  12'h008
`define BJC_OFF_EXT    12'h00C
`define BJC_OFF_PC     12'h010
`define BJC_OFF_SR     12'h014
`define BJC_OFF_SP     12'h018
`define BJC_OFF_RN     12'h020
`define BJC_OFF_NN     12'h040

// ************************************************************
// instruction encodings
// ************************************************************
`define BJC_BT_GROUP     4'hA
`define BJC_CALL_EA_HI   8'h0B
`define BJC_CALL_EA_MID  2'h3
`define BJC_CALL_EA_LO   8'h80
`define BJC_CALL_SHORT   12'h0D0
`define BJC_BIT_MAX      5'h17
`define BJC_IO_HI_BASE   10'h3FF
`define BJC_IO_LO_BASE   10'h3FE

// ************************************************************
// condition code bits and reset values
// ************************************************************
`define BJC_CCR_S        7
`define BJC_CCR_L        6
`define BJC_RST_PC       16'h0000
`define BJC_RST_SR       16'h0300
`define BJC_RST_SP       16'h0000

`endif

//--- rtl/bjc_pkg.sv
/*
  bjc_pkg: types shared by the call unit and its testbench.
  Assumes: nothing beyond the params header.
*/
`default_nettype none

package bjc_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_OPND = 3'b010,
    ST_EXEC = 3'b100
  } bjc_state_t;

  typedef enum logic [2:0]
  {
    OP_NONE, OP_JUMP_SET, OP_CALL_SET, OP_CALL_CLR, OP_CALL_EA, OP_CALL_SHORT
  } bjc_op_t;

  typedef enum logic [2:0]
  {
    FM_EA = 3'h0, FM_ABS = 3'h1, FM_IO_HI = 3'h2, FM_IO_LO = 3'h3, FM_REG = 3'h4
  } bjc_form_t;

  typedef struct packed
  {
    logic valid;
    logic is_reg;
    logic space_y;
    logic [15:0] addr;
    logic [5:0] reg_code;
  } bjc_opnd_req_t;

  typedef struct packed
  {
    logic we;
    logic [15:0] ptr;
    logic [15:0] high;
    logic [15:0] low;
  } bjc_stack_wr_t;

endpackage : bjc_pkg

`default_nettype wire

//--- verif/tb_bjc_core.sv
/*
  tb_bjc_core: self-checking bench for the bit-test jump and call unit.
  Assumes: apb answers with pready; operand word is held as a level from
  before the go write, so it is valid the cycle after the request pulse.
*/
`default_nettype none

`define TB_CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); \
    end \
  end

module tb_bjc_core;
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // signals and instance
  // ************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic opnd_scale, opnd_limit, flush, done, fl, err, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, q, u;
  logic [23:0] opnd_rdata;
  logic [23:0] bad [3];
  bjc_pkg::bjc_opnd_req_t opnd_req, req;
  bjc_pkg::bjc_stack_wr_t stk_wr, sw;
  logic [15:0] m_pc, m_sp, m_sr;
  int n_errors, total_checks;

  bjc_core u_bjc_core
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .opnd_req(opnd_req), .opnd_rdata(opnd_rdata), .opnd_scale(opnd_scale),
    .opnd_limit(opnd_limit), .stk_wr(stk_wr), .flush(flush), .done(done)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // returns {updated rn, operand address}
  function automatic logic [31:0] eac(input logic [2:0] m, input logic [15:0] r,
                                      input logic [15:0] n);
    case (m)
      3'd0: return {r - n, r};
      3'd1: return {r + n, r};
      3'd2: return {r - 16'd1, r};
      3'd3: return {r + 16'd1, r};
      3'd5: return {r, r + n};
      3'd7: return {r - 16'd1, r - 16'd1};
      default: return {r, r};
    endcase
  endfunction : eac

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic go();
    apb(1'b1, 12'h000, 32'h1);
    seen = 1'b0;
    fl = 1'b0;
    sw = '0;
    repeat (8)
    begin
      @(posedge pclk);
      if (opnd_req.valid === 1'b1)
      begin
        req = opnd_req;
        seen = 1'b1;
      end
      if (done === 1'b1)
      begin
        fl = flush;
        sw = stk_wr;
        break;
      end
    end
    `TB_CHK(done, 1'b1)
  endtask : go

  task automatic post(input logic tk, input logic ps, input logic [15:0] tgt,
                      input logic [15:0] ret, input logic [15:0] nsr);
    `TB_CHK(fl, tk)
    `TB_CHK(sw.we, ps)
    if (ps)
    begin
      m_sp = m_sp + 16'd1;
      `TB_CHK(sw.ptr, m_sp)
      `TB_CHK(sw.high, ret)
      `TB_CHK(sw.low, m_sr)
    end
    m_pc = tk ? tgt : ret;
    m_sr = nsr;
    apb(1'b0, 12'h010, 32'h0);
    `TB_CHK(q, {16'h0, m_pc})
    apb(1'b0, 12'h018, 32'h0);
    `TB_CHK(q, {16'h0, m_sp})
    apb(1'b0, 12'h014, 32'h0);
    `TB_CHK(q, {16'h0, m_sr})
    apb(1'b0, 12'h004, 32'h0);
    `TB_CHK(q[2:0], {tk, 2'b00})
  endtask : post

  task automatic bt(input logic [1:0] op, input logic [2:0] fm, input logic [4:0] bn,
                    input logic hit);
    logic [31:0] e;
    logic [15:0] rv, nv, ext;
    logic [5:0] fld;
    logic sy, sc, li, tk;
    logic [23:0] dat;
    u = rnd();
    fld = u[5:0];
    sy = u[8];
    sc = u[9];
    li = u[10];
    ext = u[31:16];
    if (fm == 3'd0 && fld[5:3] == 3'd6)
      fld[5:3] = 3'd7;
    u = rnd();
    rv = u[15:0];
    nv = u[31:16];
    u = rnd();
    dat = u[23:0];
    dat[bn] = hit;
    case (fm)
      3'd0: e = eac(fld[5:3], rv, nv);
      3'd1: e = {16'h0, 10'h000, fld};
      3'd2: e = {16'h0, 10'h3FF, fld};
      3'd3: e = {16'h0, 10'h3FE, fld};
      default: e = '0;
    endcase
    if (fm == 3'd0)
    begin
      apb(1'b1, {7'h01, fld[2:0], 2'b00}, {16'h0, rv});
      apb(1'b1, {7'h02, fld[2:0], 2'b00}, {16'h0, nv});
    end
    opnd_rdata <= dat;
    opnd_scale <= sc;
    opnd_limit <= li;
    apb(1'b1, 12'h008, {8'h0, 4'hA, op, fm, sy, fld, 3'b000, bn});
    apb(1'b1, 12'h00C, {16'h0, ext});
    go();
    tk = (op == 2'd2) ? !hit : hit;
    `TB_CHK(seen, 1'b1)
    `TB_CHK(req.is_reg, (fm == 3'd4))
    if (fm == 3'd4)
      `TB_CHK(req.reg_code, fld)
    else
    begin
      `TB_CHK(req.space_y, sy)
      `TB_CHK(req.addr, e[15:0])
    end
    post(tk, tk && op != 2'd0, ext, m_pc + 16'd2, m_sr | {8'h0, sc, li, 6'h0});
    if (fm == 3'd0)
    begin
      apb(1'b0, {7'h01, fld[2:0], 2'b00}, 32'h0);
      `TB_CHK(q[15:0], e[31:16])
    end
  endtask : bt

  // ************************************************************
  // watchdog
  // ************************************************************
  initial
  begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    seed = 32'hB5C518D4;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    opnd_rdata = '0;
    opnd_scale = 1'b0;
    opnd_limit = 1'b0;
    n_errors = 0;
    total_checks = 0;
    m_pc = 16'h0000;
    m_sp = 16'h0000;
    m_sr = 16'h0300;
    bad[0] = 24'hA08018;
    bad[1] = 24'hAC8000;
    bad[2] = 24'h0BDA81;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h014, 32'h0);
    `TB_CHK(q, 32'h0000_0300)
    apb(1'b0, 12'h01C, 32'h0);
    `TB_CHK({err, q}, 33'h0_0000_0000 | 33'h1_0000_0000)
    $display("reset and unmapped test done");
    for (int op = 0; op < 3; op++)
      for (int fm = 0; fm < 5; fm++)
        for (int h = 0; h < 2; h++)
          bt(op[1:0], fm[2:0], (h == 1) ? 5'd23 : {op[1:0], fm[2:0]}, h[0]);
    for (int i = 0; i < 40; i++)
    begin
      u = rnd();
      bt((u[1:0] == 2'd3) ? 2'd1 : u[1:0], (u[4:2] > 3'd4) ? 3'd4 : u[4:2],
         u[5] ? 5'd23 : {1'b0, u[9:6]}, u[11]);
    end
    $display("bit test jumps and calls done");
    for (int i = 0; i < 3; i++)
    begin
      u = rnd();
      apb(1'b1, 12'h008, {8'h0, 12'h0D0, u[11:0]});
      go();
      post(1'b1, 1'b1, {4'h0, u[11:0]}, m_pc + 16'd1, m_sr);
    end
    u = rnd();
    apb(1'b1, 12'h008, 32'h000B_F080);
    apb(1'b1, 12'h00C, {16'h0, u[15:0]});
    go();
    post(1'b1, 1'b1, u[15:0], m_pc + 16'd2, m_sr);
    apb(1'b1, 12'h028, {16'h0, u[31:16]});
    apb(1'b1, 12'h008, 32'h000B_DA80);
    go();
    post(1'b1, 1'b1, u[31:16], m_pc + 16'd1, m_sr);
    apb(1'b0, 12'h028, 32'h0);
    `TB_CHK(q[15:0], u[31:16] + 16'd1)
    $display("subroutine calls done");
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 12'h008, {8'h0, bad[i]});
      go();
      `TB_CHK({fl, sw.we}, 2'b00)
      apb(1'b0, 12'h004, 32'h0);
      `TB_CHK(q[1], 1'b1)
      apb(1'b0, 12'h010, 32'h0);
      `TB_CHK(q, {16'h0, m_pc})
    end
    $display("illegal encodings done");
    test_done();
  end
endmodule : tb_bjc_core

`undef TB_CHK
`default_nettype wire
